/* bench/radio_mode_sequencer_bench.sv */
// self-checking bench for the radio mode sequencer
`timescale 1ns/1ps
`include "rms_cfg.svh"
module radio_mode_sequencer_bench;
  import rms_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  rms_byte_t a = 8'h00;
  rms_byte_t wd = 8'h00;
  rms_byte_t rdat;
  rms_byte_t v;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ck = 1'b0;
  logic [2:0] req = 3'h0;
  logic pre, syn, pay, txd, rel;
  rms_mode_t mode;
  logic [4:0] pin;
  int error_cnt = 0;
  int checks = 0;
  int n, m, rel_cnt;
  always #2.5 clock = ~clock;
  // short timer step keeps the interval counts small
  rms_sequencer #(.TICK_CYC(4)) DUT (.clock(clock), .reset_n(reset_n), .reg_addr(a),
    .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .preamble_found(pre),
    .sync_word_match(syn), .payload_complete(pay), .check_pass_flag(ck),
    .transmit_done_flag(txd), .queue_threshold_flag(1'b0), .queue_drained_flag(1'b0),
    .radio_mode(mode), .tx_payload_reload(rel), .event_pin(pin));
  rms_radio_model u_radio (.clock(clock), .reset_n(reset_n), .radio_mode(mode), .ev_req(req),
    .preamble_found(pre), .sync_word_match(syn), .payload_complete(pay),
    .transmit_done_flag(txd));
  // reload pulses counted apart, their exact cycle is the designer's choice
  always @(posedge clock) if (rel === 1'b1) rel_cnt++;
  task cmp(input logic [7:0] g, input logic [7:0] e, input string s);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h exp %h", $time, s, g, e);
    end
  endtask : cmp
  task near(input int g, input int e, input string s);
    cmp(8'((g > e - 4) && (g < e + 4)), 8'h01, s);
  endtask : near
  task wr_r(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clock);
    a <= ad;
    wd <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_r
  task rd_r(input logic [7:0] ad);
    @(posedge clock);
    a <= ad;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 v = rdat;
  endtask : rd_r
  task run(input logic [1:0] md, output int c);
    c = 0;
    while (mode === md && c < 2000) begin
      @(posedge clock);
      #1 c++;
    end
  endtask : run
  task await(input logic [1:0] md);
    m = 0;
    while (mode !== md && m < 2000) begin
      @(posedge clock);
      #1 m++;
    end
    cmp(8'(m < 2000), 8'h01, "mode reached");
  endtask : await
  task ev(input int i);
    @(posedge clock);
    req[i] <= 1'b1;
    @(posedge clock);
    req[i] <= 1'b0;
  endtask : ev
  task park;
    wr_r(`RMS_ADDR_SEQ1, 8'h40);
    wr_r(`RMS_ADDR_OPMODE, 8'h00);
  endtask : park
  task t_reset;
    rd_r(`RMS_ADDR_STAT); cmp(v, 8'h00, "status");
    rd_r(`RMS_ADDR_T1); cmp(v, `RMS_RST_TIMER, "timer one");
    rd_r(8'h3F); cmp(v, 8'h00, "unmapped");
    $display("test reset done");
  endtask : t_reset
  task t_listen;
    wr_r(`RMS_ADDR_T1, 8'h02);
    wr_r(`RMS_ADDR_T2, 8'h03);
    wr_r(`RMS_ADDR_SEQ2, 8'hC0);
    wr_r(`RMS_ADDR_MAPHI, 8'h07);
    wr_r(`RMS_ADDR_SEQ1, 8'hA6);
    await(`RMS_MODE_RX);
    run(`RMS_MODE_RX, n); near(n, 12, "receive span");
    cmp(mode, `RMS_MODE_SLEEP, "sleep idle");
    run(`RMS_MODE_SLEEP, m); near(n + m, 20, "cycle");
    run(`RMS_MODE_RX, n); near(n, 12, "second span");
    // preamble starts in sleep and outlasts T1 plus twice T2, so the next poll must catch it
    @(posedge clock);
    req[0] <= 1'b1;
    await(`RMS_MODE_RX);
    repeat (2) @(posedge clock);
    #1 cmp(pin[4], 1'b1, "pin four");
    repeat (30) @(posedge clock);
    req[0] <= 1'b0;
    rd_r(`RMS_ADDR_STAT); cmp(v & 8'h0F, 8'h08, "off in rx");
    $display("test listen done");
  endtask : t_listen
  task t_sync;
    park;
    wr_r(`RMS_ADDR_T1, 8'h01);
    wr_r(`RMS_ADDR_T2, 8'h64);
    wr_r(`RMS_ADDR_WIN, 8'h01);
    wr_r(`RMS_ADDR_SEQ2, 8'hB0);
    wr_r(`RMS_ADDR_MAPLO, 8'h31);
    wr_r(`RMS_ADDR_SEQ1, 8'hA6);
    await(`RMS_MODE_RX);
    run(`RMS_MODE_RX, n); near(n, 200, "window");
    await(`RMS_MODE_RX);
    ev(0);
    run(`RMS_MODE_RX, n); near(n + 2, 400, "held to timer two");
    wr_r(`RMS_ADDR_FLAGS, 8'hFF);
    await(`RMS_MODE_RX);
    ev(0);
    ev(1);
    @(posedge clock);
    #1 cmp(pin[2], 1'b1, "sync pin");
    ev(2);
    repeat (3) @(posedge clock);
    rd_r(`RMS_ADDR_STAT); cmp(v & 8'h0F, 8'h08, "off on sync");
    rd_r(`RMS_ADDR_FLAGS); cmp(v & 8'h07, 8'h07, "packet flags");
    $display("test sync done");
  endtask : t_sync
  task t_beacon;
    park;
    wr_r(`RMS_ADDR_T1, 8'h02);
    wr_r(`RMS_ADDR_T2, 8'h03);
    wr_r(`RMS_ADDR_PKT2, 8'h08);
    rel_cnt = 0;
    wr_r(`RMS_ADDR_SEQ1, 8'hA4);
    await(`RMS_MODE_TX);
    run(`RMS_MODE_TX, n);
    cmp(mode, `RMS_MODE_SLEEP, "idle after sent");
    run(`RMS_MODE_SLEEP, m); near(n + m, 20, "beacon period");
    cmp(mode, `RMS_MODE_TX, "again tx");
    repeat (2) @(posedge clock);
    cmp(8'(rel_cnt), 8'h02, "reloads");
    wr_r(`RMS_ADDR_SEQ1, 8'h40);
    rd_r(`RMS_ADDR_STAT); cmp(v & 8'h03, 8'h00, "halted");
    $display("test beacon done");
  endtask : t_beacon
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // whole run is about a thousand cycles, the 20000-cycle limit leaves a wide margin
  initial begin
    #100000;
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    t_reset;
    t_listen;
    t_sync;
    t_beacon;
    tally_and_finish;
  end
endmodule : radio_mode_sequencer_bench

/* bench/rms_radio_model.sv */
// radio front end model facing the sequencer's event inputs
`timescale 1ns/1ps
`include "rms_cfg.svh"
module rms_radio_model (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [1:0] radio_mode,
  input wire logic [2:0] ev_req,
  output logic preamble_found,
  output logic sync_word_match,
  output logic payload_complete,
  output logic transmit_done_flag
);
  logic [1:0] tx_cnt_q;
  // a sleeping receiver hears nothing, so requests outside receive are dropped
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      {payload_complete, sync_word_match, preamble_found} <= 3'h0;
    end else begin
      {payload_complete, sync_word_match, preamble_found} <=
        ev_req & {3{radio_mode == `RMS_MODE_RX}};
    end
  end
  // packet leaves a few cycles after transmit entry, one sent pulse per packet
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_cnt_q <= 2'h0;
      transmit_done_flag <= 1'b0;
    end else if (radio_mode != `RMS_MODE_TX) begin
      tx_cnt_q <= 2'h0;
      transmit_done_flag <= 1'b0;
    end else begin
      tx_cnt_q <= (tx_cnt_q == 2'h3) ? tx_cnt_q : tx_cnt_q + 2'h1;
      transmit_done_flag <= (tx_cnt_q == 2'h2);
    end
  end
endmodule : rms_radio_model

/* src/rms_cfg.svh */
// register map, field positions, reset values and timing constants of the mode sequencer
`ifndef RMS_CFG_SVH
`define RMS_CFG_SVH

// register offsets
`define RMS_ADDR_SEQ1 8'h00
`define RMS_ADDR_SEQ2 8'h01
`define RMS_ADDR_T1 8'h02
`define RMS_ADDR_T2 8'h03
`define RMS_ADDR_WIN 8'h04
`define RMS_ADDR_MAPLO 8'h05
`define RMS_ADDR_MAPHI 8'h06
`define RMS_ADDR_PKT2 8'h07
`define RMS_ADDR_STAT 8'h08
`define RMS_ADDR_FLAGS 8'h09
`define RMS_ADDR_OPMODE 8'h0A

// sequence_config_first fields
`define RMS_SEQ1_START 7
`define RMS_SEQ1_HALT 6
`define RMS_SEQ1_IDLE_KIND 5
`define RMS_SEQ1_START_TR 3
`define RMS_SEQ1_LP_CHOICE 2
`define RMS_SEQ1_IDLE_EXIT 1
`define RMS_SEQ1_TX_EXIT 0
// sequence_config_second fields
`define RMS_SEQ2_RX_EXIT 5
`define RMS_SEQ2_RXTO_TR 3
// pin map high fields
`define RMS_MAPHI_PRE_SEL 2
// packet_config_second fields
`define RMS_PKT2_PERIODIC 3

// reset values
`define RMS_RST_SEQ1 8'h00
`define RMS_RST_SEQ2 8'h00
`define RMS_RST_TIMER 8'h01
`define RMS_RST_WIN 8'h00
`define RMS_RST_MAP 8'h00

// radio mode codes driven to the analog side
`define RMS_MODE_SLEEP 2'h0
`define RMS_MODE_STBY 2'h1
`define RMS_MODE_RX 2'h2
`define RMS_MODE_TX 2'h3

// transition codes
`define RMS_RXEX_PREAMBLE 3'h6
`define RMS_RXEX_SYNC 3'h5
`define RMS_RXEX_PAYLOAD 3'h0
`define RMS_RXEX_CHECK 3'h1
`define RMS_ST_RX 2'h1
`define RMS_ST_TX 2'h2
`define RMS_TO_RX 2'h0
`define RMS_TO_TX 2'h1
`define RMS_TO_LP 2'h2

// timing: interval timer step and receive window step
`define RMS_CLK_MHZ 200
`define RMS_TICK_NS 64000
`define RMS_WIN_TICK_NS 1000

`endif

/* src/rms_pin_map.sv */
// event pin multiplexer: five pins, each picks one of four sources by a two-bit code; only pin two has four events, the other pins have one code tied low
`timescale 1ns/1ps
module rms_pin_map (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [9:0] pin_sel,
  input wire logic preamble_pin_map_sel,
  input wire logic payload_complete,
  input wire logic check_pass_flag,
  input wire logic transmit_done_flag,
  input wire logic queue_threshold_flag,
  input wire logic queue_drained_flag,
  input wire logic sync_word_match,
  input wire logic preamble_found,
  input wire logic window_timeout,
  input wire logic seq_running,
  output logic [4:0] event_pin
);
  logic [3:0] src [5];
  logic pin_q [5];

  // candidate events per pin, indexed by code
  assign src[0] = {1'b0, transmit_done_flag, check_pass_flag, payload_complete};
  assign src[1] = {1'b0, payload_complete, queue_drained_flag, queue_threshold_flag};
  assign src[2] = {sync_word_match, transmit_done_flag, queue_threshold_flag, payload_complete};
  assign src[3] = {1'b0, transmit_done_flag, sync_word_match, queue_drained_flag};
  // code 11 on pin four carries the preamble only with the map bit set
  assign src[4] = {preamble_pin_map_sel ? preamble_found : window_timeout,
                   1'b0, seq_running, transmit_done_flag};

  // registered so every pin changes right after a clock edge
  for (genvar i = 0; i < 5; i++) begin : g_pin
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        pin_q[i] <= 1'b0;
      end else begin
        pin_q[i] <= src[i][pin_sel[2*i +: 2]];
      end
    end
    assign event_pin[i] = pin_q[i];
  end
endmodule : rms_pin_map

/* src/rms_pkg.sv */
// types shared by the mode sequencer files
package rms_pkg;
  typedef enum logic [1:0] {RMS_OFF, RMS_IDLE, RMS_RX, RMS_TX} rms_state_e;
  typedef logic [7:0] rms_byte_t;
  typedef logic [1:0] rms_mode_t;
endpackage : rms_pkg

/* src/rms_sequencer.sv */
// autonomous radio mode sequencer: idle, receive and transmit cycling with register port
// Function
// - listen mode wakes receiver every T1 plus T2, receiving for T2.
// - no preamble within receive window returns radio to sleep idle.
// - wake on preamble: preamble stops sequencer, radio stays receiving.
// - receive exit code 110 stops sequencer on preamble found.
// - idle sleep, start to low power choice, idle, idle exit 1 to receive.
// - second timer bounds receive time while no preamble is found.
// - wake on sync receives only during window, low power otherwise.
// - preamble before window end keeps receiving until T2, then resumes.
// - sync match fires event, stops sequencer, keeps receiving.
// - receive exit 101 stops on sync; timeout code 10 to low power.
// - preamble found event can be routed to event pin four.
// - beacon enters transmit every T1 plus T2, idles after sent.
// - periodic enable reloads identical payload each cycle without host.
// - beacon loop runs until the host sets the halt bit.
// - transmit exit 0 to low power on sent; idle exit 0 to transmit.
`timescale 1ns/1ps
`include "rms_cfg.svh"
module rms_sequencer #(
  parameter int TICK_CYC = (`RMS_TICK_NS * `RMS_CLK_MHZ) / 1000
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire rms_pkg::rms_byte_t reg_addr,
  input wire rms_pkg::rms_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output rms_pkg::rms_byte_t reg_rdata,
  input wire logic preamble_found,
  input wire logic sync_word_match,
  input wire logic payload_complete,
  input wire logic check_pass_flag,
  input wire logic transmit_done_flag,
  input wire logic queue_threshold_flag,
  input wire logic queue_drained_flag,
  output rms_pkg::rms_mode_t radio_mode,
  output logic tx_payload_reload,
  output logic [4:0] event_pin
);
  import rms_pkg::*;

  localparam int WIN_CYC = (`RMS_WIN_TICK_NS * `RMS_CLK_MHZ) / 1000;

  rms_byte_t seq1_q, seq2_q, t1_per_q, t2_per_q, win_q, maplo_q, maphi_q, pkt2_q;
  rms_byte_t rdata_q;
  logic [4:0] flags_q;
  rms_state_e state_q, state_d;
  rms_mode_t mode_q, mode_d;
  logic pre_seen_q, reload_q, restart_rx;
  logic t1_exp, t2_exp, win_exp, t1_busy, t2_busy, win_busy;
  logic t1_start, t2_start, win_start, timers_stop;
  logic enter_idle, enter_tx, rx_exit_hit;

  // write decode; start and halt are action bits, never stored
  logic wr_seq1;
  logic start_req, halt_req;
  assign wr_seq1 = reg_wr && (reg_addr == `RMS_ADDR_SEQ1);
  assign start_req = wr_seq1 && reg_wdata[`RMS_SEQ1_START];
  assign halt_req = wr_seq1 && reg_wdata[`RMS_SEQ1_HALT];

  // configuration fields
  logic idle_kind_select, low_power_choice, idle_exit_transition, transmit_exit_transition;
  logic [1:0] start_transition, rx_timeout_transition;
  logic [2:0] receive_exit_transition;
  logic periodic_tx_enable;
  rms_mode_t lp_mode;
  rms_state_e lp_state;
  assign idle_kind_select = seq1_q[`RMS_SEQ1_IDLE_KIND];
  assign start_transition = seq1_q[`RMS_SEQ1_START_TR +: 2];
  assign low_power_choice = seq1_q[`RMS_SEQ1_LP_CHOICE];
  assign idle_exit_transition = seq1_q[`RMS_SEQ1_IDLE_EXIT];
  assign transmit_exit_transition = seq1_q[`RMS_SEQ1_TX_EXIT];
  assign receive_exit_transition = seq2_q[`RMS_SEQ2_RX_EXIT +: 3];
  assign rx_timeout_transition = seq2_q[`RMS_SEQ2_RXTO_TR +: 2];
  assign periodic_tx_enable = pkt2_q[`RMS_PKT2_PERIODIC];
  // low power choice: idle kind 1 is sleep with the rc oscillator kept on
  assign lp_mode = idle_kind_select ? `RMS_MODE_SLEEP : `RMS_MODE_STBY;
  assign lp_state = low_power_choice ? RMS_IDLE : RMS_OFF;

  // configuration registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      seq1_q <= `RMS_RST_SEQ1;
      seq2_q <= `RMS_RST_SEQ2;
      t1_per_q <= `RMS_RST_TIMER;
      t2_per_q <= `RMS_RST_TIMER;
      win_q <= `RMS_RST_WIN;
      maplo_q <= `RMS_RST_MAP;
      maphi_q <= `RMS_RST_MAP;
      pkt2_q <= `RMS_RST_MAP;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `RMS_ADDR_SEQ1: seq1_q <= {2'b00, reg_wdata[5:0]};
        `RMS_ADDR_SEQ2: seq2_q <= {reg_wdata[7:3], 3'b000};
        `RMS_ADDR_T1: t1_per_q <= reg_wdata;
        `RMS_ADDR_T2: t2_per_q <= reg_wdata;
        `RMS_ADDR_WIN: win_q <= reg_wdata;
        `RMS_ADDR_MAPLO: maplo_q <= reg_wdata;
        `RMS_ADDR_MAPHI: maphi_q <= {5'b00000, reg_wdata[2:0]};
        `RMS_ADDR_PKT2: pkt2_q <= {4'h0, reg_wdata[3], 3'b000};
        default: ;
      endcase
    end
  end

  // receive exit condition selected by the exit code
  always_comb begin
    unique case (receive_exit_transition)
      `RMS_RXEX_PREAMBLE: rx_exit_hit = preamble_found;
      `RMS_RXEX_SYNC: rx_exit_hit = sync_word_match;
      `RMS_RXEX_PAYLOAD: rx_exit_hit = payload_complete;
      `RMS_RXEX_CHECK: rx_exit_hit = check_pass_flag;
      default: rx_exit_hit = 1'b0;
    endcase
  end

  // next state; halt beats start, start beats the running sequence
  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    restart_rx = 1'b0;
    if (halt_req) begin
      state_d = RMS_OFF;
    end else if (start_req) begin
      // a start write acts on the fields it carries, the stored copy is one cycle stale
      unique case (reg_wdata[`RMS_SEQ1_START_TR +: 2])
        `RMS_ST_RX: begin
          state_d = RMS_RX;
          mode_d = `RMS_MODE_RX;
        end
        `RMS_ST_TX: begin
          state_d = RMS_TX;
          mode_d = `RMS_MODE_TX;
        end
        default: begin
          state_d = reg_wdata[`RMS_SEQ1_LP_CHOICE] ? RMS_IDLE : RMS_OFF;
          mode_d = reg_wdata[`RMS_SEQ1_IDLE_KIND] ? `RMS_MODE_SLEEP : `RMS_MODE_STBY;
        end
      endcase
    end else begin
      unique case (state_q)
        RMS_OFF: begin
          // off: the radio holds its mode until the host picks another
          if (reg_wr && reg_addr == `RMS_ADDR_OPMODE) begin
            mode_d = reg_wdata[1:0];
          end
        end
        RMS_IDLE: begin
          if (t1_exp && idle_exit_transition) begin
            state_d = RMS_RX;
            mode_d = `RMS_MODE_RX;
          end else if (t1_exp) begin
            state_d = RMS_TX;
            mode_d = `RMS_MODE_TX;
          end
        end
        RMS_RX: begin
          if (rx_exit_hit) begin
            state_d = RMS_OFF;
          end else if (win_exp && !pre_seen_q) begin
            unique case (rx_timeout_transition)
              `RMS_TO_RX: restart_rx = 1'b1;
              `RMS_TO_TX: begin
                state_d = RMS_TX;
                mode_d = `RMS_MODE_TX;
              end
              `RMS_TO_LP: begin
                state_d = lp_state;
                mode_d = lp_mode;
              end
              default: state_d = RMS_OFF;
            endcase
          end else if (t2_exp) begin
            state_d = lp_state;
            mode_d = lp_mode;
          end
        end
        RMS_TX: begin
          if (transmit_done_flag && transmit_exit_transition) begin
            state_d = RMS_RX;
            mode_d = `RMS_MODE_RX;
          end else if (transmit_done_flag) begin
            state_d = lp_state;
            mode_d = lp_mode;
          end
        end
      endcase
    end
  end

  // timer control: idle waits out the rest of T2, then T1, so a cycle is T1 plus T2
  assign enter_idle = (state_d == RMS_IDLE) && (state_q != RMS_IDLE);
  assign enter_tx = (state_d == RMS_TX) && (state_q != RMS_TX);
  assign t2_start = ((state_d == RMS_RX) && (state_q != RMS_RX || restart_rx)) || enter_tx;
  assign win_start = (state_d == RMS_RX) && (state_q != RMS_RX || restart_rx) && (win_q != 8'h00);
  assign t1_start = (enter_idle && !t2_busy) || (state_q == RMS_IDLE && t2_exp);
  assign timers_stop = (state_d == RMS_OFF);

  rms_timer #(.TICK_CYC(16'(TICK_CYC))) u_first_interval_timer (
    .clock(clock),
    .reset_n(reset_n),
    .start(t1_start),
    .stop(timers_stop),
    .period(t1_per_q),
    .busy(t1_busy),
    .expire(t1_exp)
  );

  rms_timer #(.TICK_CYC(16'(TICK_CYC))) u_second_interval_timer (
    .clock(clock),
    .reset_n(reset_n),
    .start(t2_start),
    .stop(timers_stop),
    .period(t2_per_q),
    .busy(t2_busy),
    .expire(t2_exp)
  );

  // window stops early once a preamble is seen, so it cannot fire late
  rms_timer #(.TICK_CYC(16'(WIN_CYC))) u_receive_window_limit (
    .clock(clock),
    .reset_n(reset_n),
    .start(win_start),
    .stop(timers_stop || pre_seen_q),
    .period(win_q),
    .busy(win_busy),
    .expire(win_exp)
  );

  // sequencer state and radio mode
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= RMS_OFF;
      mode_q <= `RMS_MODE_SLEEP;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
    end
  end

  // preamble seen during the current receive visit
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pre_seen_q <= 1'b0;
    end else if (state_d != RMS_RX || t2_start) begin
      pre_seen_q <= 1'b0;
    end else if (preamble_found) begin
      pre_seen_q <= 1'b1;
    end
  end

  // payload reload pulse: identical beacon sent again without host writes
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reload_q <= 1'b0;
    end else begin
      reload_q <= enter_tx && periodic_tx_enable;
    end
  end

  // sticky event flags, write one to clear; a new event beats the clear
  logic [4:0] flag_set, flag_clr;
  assign flag_set = {win_exp && !pre_seen_q, transmit_done_flag, payload_complete,
                     sync_word_match, preamble_found};
  assign flag_clr = (reg_wr && reg_addr == `RMS_ADDR_FLAGS) ? reg_wdata[4:0] : 5'b00000;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flags_q <= 5'b00000;
    end else begin
      flags_q <= (flags_q & ~flag_clr) | flag_set;
    end
  end

  // read port: data valid only in the cycle after the strobe
  logic [1:0] state_code;
  always_comb begin
    unique case (state_q)
      RMS_OFF: state_code = 2'h0;
      RMS_IDLE: state_code = 2'h1;
      RMS_RX: state_code = 2'h2;
      RMS_TX: state_code = 2'h3;
    endcase
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else if (!reg_rd) begin
      rdata_q <= 8'h00;
    end else begin
      unique case (reg_addr)
        `RMS_ADDR_SEQ1: rdata_q <= seq1_q;
        `RMS_ADDR_SEQ2: rdata_q <= seq2_q;
        `RMS_ADDR_T1: rdata_q <= t1_per_q;
        `RMS_ADDR_T2: rdata_q <= t2_per_q;
        `RMS_ADDR_WIN: rdata_q <= win_q;
        `RMS_ADDR_MAPLO: rdata_q <= maplo_q;
        `RMS_ADDR_MAPHI: rdata_q <= maphi_q;
        `RMS_ADDR_PKT2: rdata_q <= pkt2_q;
        `RMS_ADDR_STAT: rdata_q <= {t1_busy, t2_busy, win_busy, pre_seen_q, mode_q, state_code};
        `RMS_ADDR_FLAGS: rdata_q <= {3'b000, flags_q};
        `RMS_ADDR_OPMODE: rdata_q <= {6'b000000, mode_q};
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  rms_pin_map u_pin_map (
    .clock(clock),
    .reset_n(reset_n),
    .pin_sel({maphi_q[1:0], maplo_q}),
    .preamble_pin_map_sel(maphi_q[`RMS_MAPHI_PRE_SEL]),
    .payload_complete(payload_complete),
    .check_pass_flag(check_pass_flag),
    .transmit_done_flag(transmit_done_flag),
    .queue_threshold_flag(queue_threshold_flag),
    .queue_drained_flag(queue_drained_flag),
    .sync_word_match(sync_word_match),
    .preamble_found(preamble_found),
    .window_timeout(win_exp && !pre_seen_q),
    .seq_running(state_q != RMS_OFF),
    .event_pin(event_pin)
  );

  assign reg_rdata = rdata_q;
  assign radio_mode = mode_q;
  assign tx_payload_reload = reload_q;

  // checks on sequencer behaviour
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_pre_stop: assert property (state_q == RMS_RX && !halt_req && !start_req
    && receive_exit_transition == `RMS_RXEX_PREAMBLE && preamble_found
    |=> (state_q == RMS_OFF && radio_mode == `RMS_MODE_RX) [*2])
    else $error("preamble did not stop sequencer in receive");
  a_sync_stop: assert property (state_q == RMS_RX && !halt_req && !start_req
    && receive_exit_transition == `RMS_RXEX_SYNC && sync_word_match
    |=> state_q == RMS_OFF && radio_mode == `RMS_MODE_RX)
    else $error("sync match did not stop sequencer");
  a_idle_wake: assert property (state_q == RMS_IDLE && t1_exp && !halt_req && !start_req
    |=> state_q == ($past(idle_exit_transition) ? RMS_RX : RMS_TX))
    else $error("idle exit went to wrong state");
  a_rx_bound: assert property (state_q == RMS_RX && t2_exp && !rx_exit_hit
    && !halt_req && !start_req && !(win_exp && !pre_seen_q)
    |=> state_q != RMS_RX)
    else $error("receive outlived second timer");
  a_sleep_idle: assert property (state_q == RMS_IDLE && idle_kind_select
    |-> radio_mode == `RMS_MODE_SLEEP)
    else $error("idle without sleep");
  a_beacon_back: assert property (state_q == RMS_TX && transmit_done_flag
    && !transmit_exit_transition && !halt_req && !start_req
    |=> state_q == lp_state && radio_mode == lp_mode)
    else $error("transmit done did not return to low power");
  a_halt_off: assert property (halt_req |=> state_q == RMS_OFF ##1 !t1_busy && !t2_busy)
    else $error("halt did not stop sequencer");
  a_reload_tx: assert property (state_q != RMS_TX ##1 state_q == RMS_TX
    |-> tx_payload_reload == $past(periodic_tx_enable))
    else $error("reload pulse wrong on transmit entry");
  a_pin_four: assert property (preamble_found && maphi_q[1:0] == 2'b11
    && maphi_q[`RMS_MAPHI_PRE_SEL] |=> event_pin[4])
    else $error("preamble not on event pin four");
  a_t2_after: assert property (state_q == RMS_RX && $past(state_q) != RMS_RX
    |-> t2_busy)
    else $error("second timer not running in receive");

  c_idle_rx: cover property (state_q == RMS_IDLE ##1 state_q == RMS_RX);
  c_rx_off: cover property (state_q == RMS_RX ##1 state_q == RMS_OFF);
  c_tx_idle: cover property (state_q == RMS_TX ##1 state_q == RMS_IDLE);
endmodule : rms_sequencer

/* src/rms_timer.sv */
// programmable interval timer with a fixed step and a one-cycle expiry pulse
`timescale 1ns/1ps
module rms_timer #(
  parameter logic [15:0] TICK_CYC = 16'h3200
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic start,
  input wire logic stop,
  input wire logic [7:0] period,
  output logic busy,
  output logic expire
);
  logic [15:0] pre_q;
  logic [7:0] cnt_q;

  // start wins over stop; a zero period behaves as one step
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pre_q <= 16'h0000;
      cnt_q <= 8'h00;
      busy <= 1'b0;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        pre_q <= 16'h0000;
        cnt_q <= (period == 8'h00) ? 8'h01 : period;
      end else if (stop) begin
        busy <= 1'b0;
      end else if (busy) begin
        if (pre_q == TICK_CYC - 16'h0001) begin
          pre_q <= 16'h0000;
          if (cnt_q == 8'h01) begin
            busy <= 1'b0;
            expire <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end else begin
          pre_q <= pre_q + 16'h0001;
        end
      end
    end
  end
endmodule : rms_timer
